// ==== pscd_chk.sv ====
// pscd_chk: concurrent checks on bus handshake, divider strobes and aux gate
// assumes: bound to pscd_top; divider seven ratio is never rewritten and post ratio stays above zero
`timescale 1ns/1ps
module pscd_chk (
  input wire logic        i_clk,              // clock
  input wire logic        i_nrst,             // reset, active low
  input wire logic [8:0]  i_avs_address,      // byte address
  input wire logic        i_avs_read,         // read request
  input wire logic        i_avs_write,        // write request
  input wire logic [31:0] i_avs_writedata,    // write data
  input wire logic [3:0]  i_avs_byteenable,   // byte lanes
  input wire logic [2:0]  i_system_clock_output_low_on,    // clocks one to three running
  input wire logic [31:0] o_avs_readdata,     // read data
  input wire logic        o_avs_waitrequest,  // stall
  input wire logic [3:0]  o_system_clock_output_tick,      // clocks four to seven strobes
  input wire logic        o_post_tick,        // post-divider strobe
  input wire logic        o_aux_on            // auxiliary clock gate
);
  logic aux_wr;
  logic aux_wd_q;

  ////////////////////////////////////////////////////////////////////////////////
  // completed write to aux enable, and the bit it carried
  assign aux_wr = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
                  && i_avs_address == pscd_pkg::OFF_AUX_CLOCK_ENABLE;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aux_wd_q <= 1'b1;
    end else if (aux_wr) begin
      aux_wd_q <= i_avs_writedata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_req_pending;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_rd_done(logic [8:0] a);
    i_avs_read && !o_avs_waitrequest && i_avs_address == a;
  endsequence

  a_wait_one_cycle:
    assert property (s_req_pending |=> !o_avs_waitrequest) else $error("request not answered after one wait");
  a_wait_single_pulse:
    assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("waitrequest low too long");
  a_wait_needs_req:
    assert property (!o_avs_waitrequest |-> $past(i_avs_read || i_avs_write)) else $error("answer without request");
  a_tick7_gap:
    assert property (o_system_clock_output_tick[3] |=> (!o_system_clock_output_tick[3]) [*5]) else $error("clock seven strobe too soon");
  a_post_gap:
    assert property (o_post_tick |=> !o_post_tick) else $error("post strobe on two cycles running");
  a_aux_follow:
    assert property (aux_wr |=> ##[0:2] (o_aux_on == aux_wd_q)) else $error("aux gate did not follow enable");
  a_aux_only_write:
    assert property ($changed(o_aux_on) |-> $past(aux_wr, 1) || $past(aux_wr, 2) || $past(aux_wr, 3))
      else $error("aux gate changed without write");
  a_aux_stat_rsvd:
    assert property (s_rd_done(pscd_pkg::OFF_AUX_CLOCK_STATUS) |-> o_avs_readdata[31:1] == 31'h00000001)
      else $error("aux status upper bits wrong");
  a_pll_stat_rsvd:
    assert property (s_rd_done(pscd_pkg::OFF_PLL_STATUS) |-> o_avs_readdata[31:3] == 29'h0 && !o_avs_readdata[1])
      else $error("pll status reserved bits set");
  a_sys_low_on:
    assert property (s_rd_done(pscd_pkg::OFF_SYSTEM_CLOCK_OUTPUT_ON_STATUS)
                     |-> o_avs_readdata[2:0] == i_system_clock_output_low_on && o_avs_readdata[31:7] == 25'h0)
      else $error("system_clock_output status low bits wrong");
  a_unmapped_zero:
    assert property (i_avs_read && !o_avs_waitrequest && i_avs_address < pscd_pkg::OFF_POST_DIVIDER_CONTROL
                     |-> o_avs_readdata == 32'h0) else $error("unmapped read not zero");
endmodule

bind pscd_top pscd_chk pscd_chk_inst (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .i_system_clock_output_low_on(i_system_clock_output_low_on), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_system_clock_output_tick(o_system_clock_output_tick), .o_post_tick(o_post_tick), .o_aux_on(o_aux_on)
);

// ==== pscd_clk_div.sv ====
// pscd_clk_div: one programmable divider producing a divided-clock strobe
// assumes: ratio is applied only by an apply pulse from the control logic
`timescale 1ns/1ps
module pscd_clk_div #(
  parameter logic [4:0] RATIO_RST = 5'h00,  // ratio after reset
  parameter logic       EN_RST    = 1'b1    // enable after reset
) (
  input  wire logic       i_clk,      // pll output clock
  input  wire logic       i_rst_n,    // synchronised reset, active low
  input  wire logic       i_enable,   // divider enable
  input  wire logic [4:0] i_ratio,    // pending ratio
  input  wire logic       i_apply,    // load pending ratio, one-cycle pulse
  input  wire logic       i_restart,  // phase restart, one-cycle pulse
  output logic            o_tick,     // one pulse per ratio+1 cycles
  output logic            o_running   // divided clock is on
);

  typedef struct packed {
    logic [4:0] cnt;
    logic [4:0] ratio;
    logic       tick;
    logic       run;
  } pscd_div_s;

  pscd_div_s s_q;
  pscd_div_s s_d;

  ////////////////////////////////////////////////////////////////////////////////
  // count to the active ratio, restart phase on alignment
  always_comb begin
    s_d = s_q;
    s_d.run = i_enable;
    if (i_apply) begin
      s_d.ratio = i_ratio;
    end
    if (!i_enable || i_restart || i_apply || (s_q.cnt >= s_d.ratio)) begin
      s_d.cnt = 5'h00;
    end else begin
      s_d.cnt = s_q.cnt + 5'h01;
    end
    s_d.tick = i_enable && (s_d.cnt == 5'h00);
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '{cnt: 5'h00, ratio: RATIO_RST, tick: 1'b0, run: EN_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick    = s_q.tick;
  assign o_running = s_q.run;

endmodule

// ==== pscd_osc_settle.sv ====
// pscd_osc_settle: oscillator settling counter, flags stable when done
// assumes: started by release of the synchronised reset
`timescale 1ns/1ps
module pscd_osc_settle (
  input  wire logic i_clk,     // reference clock
  input  wire logic i_rst_n,   // synchronised reset, active low
  output logic      o_stable   // settling count complete
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        stable;
  } pscd_osc_s;

  pscd_osc_s s_q;
  pscd_osc_s s_d;

  ////////////////////////////////////////////////////////////////////////////////
  // count up once, then hold stable
  always_comb begin
    s_d = s_q;
    if (!s_q.stable) begin
      s_d.cnt = s_q.cnt + 16'h0001;
      if (s_d.cnt >= pscd_pkg::OSC_SETTLE_CYCLES) begin
        s_d.stable = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '{cnt: 16'h0000, stable: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_stable = s_q.stable;

endmodule

// ==== pscd_pkg.sv ====
// pscd_pkg: constants and types shared by the pll system_clock_output divider control block
// assumes: 32-bit avalon-mm register bus with byte addressing, one clock domain
package pscd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam int unsigned ADDR_W = 9;
  localparam logic [8:0] OFF_POST_DIVIDER_CONTROL = 9'h128;
  localparam logic [8:0] OFF_COMMAND_REGISTER     = 9'h138;
  localparam logic [8:0] OFF_PLL_STATUS           = 9'h13C;
  localparam logic [8:0] OFF_ALIGNMENT_MASK       = 9'h140;
  localparam logic [8:0] OFF_RATIO_CHANGE_STATUS  = 9'h144;
  localparam logic [8:0] OFF_AUX_CLOCK_ENABLE     = 9'h148;
  localparam logic [8:0] OFF_AUX_CLOCK_STATUS     = 9'h14C;
  localparam logic [8:0] OFF_SYSTEM_CLOCK_OUTPUT_ON_STATUS     = 9'h150;
  localparam logic [8:0] OFF_SYSCLK4_DIVIDER      = 9'h160;
  localparam logic [8:0] OFF_SYSCLK5_DIVIDER      = 9'h164;
  localparam logic [8:0] OFF_SYSCLK6_DIVIDER      = 9'h168;
  localparam logic [8:0] OFF_SYSCLK7_DIVIDER      = 9'h16C;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions and widths
  localparam int unsigned RATIO_W        = 5;
  localparam int unsigned DIV_EN_BIT     = 15;
  localparam int unsigned GO_BIT         = 0;
  localparam int unsigned BUSY_BIT       = 0;
  localparam int unsigned STABLE_BIT     = 2;
  localparam int unsigned AUX_EN_BIT     = 0;
  localparam int unsigned AUX_RSVD_BIT   = 1;
  localparam int unsigned NUM_DIV        = 4;  // dividers four to seven
  localparam int unsigned FIRST_DIV_IDX  = 3;  // mask/flag bit of clock four
  localparam int unsigned NUM_SYSTEM_CLOCK_OUTPUT     = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [4:0] SYS4_RATIO_RST  = 5'h03;
  localparam logic [4:0] SYS5_RATIO_RST  = 5'h02;
  localparam logic [4:0] SYS6_RATIO_RST  = 5'h00;
  localparam logic [4:0] RATIO_CHANGED_SEVEN_RATIO_RST  = 5'h05;
  localparam logic [4:0] POST_RATIO_RST  = 5'h01;
  localparam logic       DIV_EN_RST      = 1'b1;
  localparam logic       POST_EN_RST     = 1'b1;
  localparam logic       AUX_EN_RST      = 1'b1;
  localparam logic [6:0] ALIGN_MASK_RST  = 7'h00;
  localparam logic       AUX_RSVD_VAL    = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // cycle counts
  localparam logic [7:0]  ALIGN_CYCLES      = 8'h08;
  localparam logic [15:0] OSC_SETTLE_CYCLES = 16'h0010;

  ////////////////////////////////////////////////////////////////////////////////
  // alignment sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_ALIGN = 2'b10
  } pscd_state_e;

endpackage

// ==== pscd_top.sv ====
// pscd_top: register file, go alignment sequencer and dividers four to seven
// assumes: avalon-mm slave with byte addresses, i_clk is the pll output
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
module pscd_top (
  input  wire logic        i_clk,               // pll output, 20 MHz
  input  wire logic        i_nrst,              // async reset, active low
  input  wire logic [8:0]  i_avs_address,       // byte address
  input  wire logic        i_avs_read,          // read request
  input  wire logic        i_avs_write,         // write request
  input  wire logic [31:0] i_avs_writedata,     // write data
  input  wire logic [3:0]  i_avs_byteenable,    // byte lanes
  input  wire logic [2:0]  i_system_clock_output_low_on,     // clocks one to three running
  output logic [31:0]      o_avs_readdata,      // read data
  output logic             o_avs_waitrequest,   // stall
  output logic [3:0]       o_system_clock_output_tick,       // clocks four to seven strobes
  output logic             o_post_tick,         // post-divider strobe
  output logic             o_aux_on             // auxiliary clock gate
);

  ////////////////////////////////////////////////////////////////////////////////
  // state record
  typedef struct packed {
    pscd_pkg::pscd_state_e state;
    logic [7:0]            align_cnt;
    logic [3:0]            div_en;
    logic [3:0][4:0]       div_ratio;
    logic                  post_en;
    logic [4:0]            post_ratio;
    logic                  cmd_go;
    logic [6:0]            align_mask;
    logic [6:0]            ratio_change_status;
    logic                  aux_en;
    logic                  aux_on;
    logic [3:0]            apply;
    logic [3:0]            restart;
    logic                  post_apply;
    logic                  stall;
    logic [31:0]           rdata;
  } pscd_top_s;

  pscd_top_s s_q;
  pscd_top_s s_d;

  logic       rst_meta_q;
  logic       rst_sync_q;
  logic [3:0] div_run;
  logic       osc_stable;
  logic       busy;
  logic       req;
  logic       acc;
  logic [8:0] word_addr;
  logic [31:0] rd_val;

  ////////////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  // assertion stays asynchronous, release is clocked so no register sees a
  // recovery violation when the pin rises near an edge
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake terms
  // every request costs one stall cycle then one ready cycle; the stall gives
  // the read mux a full cycle and keeps waitrequest a plain register
  assign req       = i_avs_read || i_avs_write;
  assign acc       = req && !s_q.stall;  // transfer completes this edge
  assign word_addr = {i_avs_address[8:2], 2'b00};
  assign busy      = (s_q.state == pscd_pkg::ST_ALIGN);

  // read data mux, unmapped reads return zero
  // divider registers read back the staged ratio, not the one running
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (word_addr)
      pscd_pkg::OFF_SYSCLK4_DIVIDER,
      pscd_pkg::OFF_SYSCLK5_DIVIDER,
      pscd_pkg::OFF_SYSCLK6_DIVIDER,
      pscd_pkg::OFF_SYSCLK7_DIVIDER: begin
        rd_val[pscd_pkg::DIV_EN_BIT] = s_q.div_en[word_addr[3:2]];
        rd_val[4:0]                  = s_q.div_ratio[word_addr[3:2]];
      end
      pscd_pkg::OFF_POST_DIVIDER_CONTROL: begin
        rd_val[pscd_pkg::DIV_EN_BIT] = s_q.post_en;
        rd_val[4:0]                  = s_q.post_ratio;
      end
      pscd_pkg::OFF_COMMAND_REGISTER: begin
        rd_val[pscd_pkg::GO_BIT] = s_q.cmd_go;
      end
      pscd_pkg::OFF_PLL_STATUS: begin
        rd_val[pscd_pkg::BUSY_BIT]   = busy;
        rd_val[pscd_pkg::STABLE_BIT] = osc_stable;
      end
      pscd_pkg::OFF_ALIGNMENT_MASK: begin
        rd_val[6:0] = s_q.align_mask;
      end
      pscd_pkg::OFF_RATIO_CHANGE_STATUS: begin
        rd_val[6:0] = s_q.ratio_change_status;
      end
      pscd_pkg::OFF_AUX_CLOCK_ENABLE: begin
        rd_val[pscd_pkg::AUX_EN_BIT]   = s_q.aux_en;
        rd_val[pscd_pkg::AUX_RSVD_BIT] = pscd_pkg::AUX_RSVD_VAL;
      end
      pscd_pkg::OFF_AUX_CLOCK_STATUS: begin
        rd_val[pscd_pkg::AUX_EN_BIT]   = s_q.aux_on;
        rd_val[pscd_pkg::AUX_RSVD_BIT] = pscd_pkg::AUX_RSVD_VAL;
      end
      pscd_pkg::OFF_SYSTEM_CLOCK_OUTPUT_ON_STATUS: begin
        rd_val[2:0] = i_system_clock_output_low_on;
        rd_val[6:3] = div_run;
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic: bus slave, register writes, go sequencer
  always_comb begin
    s_d            = s_q;
    s_d.apply      = 4'h0;
    s_d.restart    = 4'h0;
    s_d.post_apply = 1'b0;
    s_d.aux_on     = s_q.aux_en;

    // one wait cycle per request, then one ready cycle; stalled while idle
    s_d.stall = !(req && s_q.stall);
    if (req && s_q.stall) begin
      s_d.rdata = rd_val;
    end

    // go sequencer: busy for a fixed count, then apply and restart in one edge
    // so every selected clock leaves alignment on the same cycle
    unique case (s_q.state)
      pscd_pkg::ST_IDLE: begin
        s_d.align_cnt = 8'h00;
      end
      pscd_pkg::ST_ALIGN: begin
        s_d.align_cnt = s_q.align_cnt + 8'h01;
        if (s_d.align_cnt >= pscd_pkg::ALIGN_CYCLES) begin
          // apply pending ratios to masked clocks and restart their phase
          for (int i = 0; i < 4; i++) begin
            if (s_q.align_mask[pscd_pkg::FIRST_DIV_IDX + i]) begin
              s_d.apply[i]   = 1'b1;
              s_d.restart[i] = 1'b1;
              s_d.ratio_change_status[pscd_pkg::FIRST_DIV_IDX + i] = 1'b0;
            end
          end
          s_d.state = pscd_pkg::ST_IDLE;
        end
      end
    endcase

    // register writes take effect at the completing edge
    if (acc && i_avs_write) begin
      unique case (word_addr)
        pscd_pkg::OFF_SYSCLK4_DIVIDER,
        pscd_pkg::OFF_SYSCLK5_DIVIDER,
        pscd_pkg::OFF_SYSCLK6_DIVIDER,
        pscd_pkg::OFF_SYSCLK7_DIVIDER: begin
          if (i_avs_byteenable[0]) begin
            s_d.div_ratio[word_addr[3:2]] = i_avs_writedata[4:0];
            // flag set after any clear above so a same-cycle change wins
            s_d.ratio_change_status[pscd_pkg::FIRST_DIV_IDX + 32'(word_addr[3:2])] = 1'b1;
          end
          if (i_avs_byteenable[1]) begin
            s_d.div_en[word_addr[3:2]] = i_avs_writedata[pscd_pkg::DIV_EN_BIT];
          end
        end
        pscd_pkg::OFF_POST_DIVIDER_CONTROL: begin
          if (i_avs_byteenable[0]) begin
            s_d.post_ratio = i_avs_writedata[4:0];
            s_d.post_apply = 1'b1;
          end
          if (i_avs_byteenable[1]) begin
            s_d.post_en = i_avs_writedata[pscd_pkg::DIV_EN_BIT];
          end
        end
        pscd_pkg::OFF_COMMAND_REGISTER: begin
          if (i_avs_byteenable[0]) begin
            s_d.cmd_go = i_avs_writedata[pscd_pkg::GO_BIT];
            // a go written while busy is stored but does not restart the count
            if (i_avs_writedata[pscd_pkg::GO_BIT] && !busy) begin
              s_d.state     = pscd_pkg::ST_ALIGN;
              s_d.align_cnt = 8'h00;
            end
          end
        end
        pscd_pkg::OFF_ALIGNMENT_MASK: begin
          if (i_avs_byteenable[0]) begin
            s_d.align_mask = i_avs_writedata[6:0];
          end
        end
        pscd_pkg::OFF_AUX_CLOCK_ENABLE: begin
          if (i_avs_byteenable[0]) begin
            s_d.aux_en = i_avs_writedata[pscd_pkg::AUX_EN_BIT];
          end
        end
        default: begin
          s_d.cmd_go = s_d.cmd_go;  // read-only or unmapped: write ignored
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= '{
        state:      pscd_pkg::ST_IDLE,
        align_cnt:  8'h00,
        div_en:     {4{pscd_pkg::DIV_EN_RST}},
        div_ratio:  {pscd_pkg::RATIO_CHANGED_SEVEN_RATIO_RST, pscd_pkg::SYS6_RATIO_RST,
                     pscd_pkg::SYS5_RATIO_RST, pscd_pkg::SYS4_RATIO_RST},
        post_en:    pscd_pkg::POST_EN_RST,
        post_ratio: pscd_pkg::POST_RATIO_RST,
        cmd_go:     1'b0,
        align_mask: pscd_pkg::ALIGN_MASK_RST,
        ratio_change_status:    7'h00,
        aux_en:     pscd_pkg::AUX_EN_RST,
        aux_on:     pscd_pkg::AUX_EN_RST,
        apply:      4'h0,
        restart:    4'h0,
        post_apply: 1'b0,
        stall:      1'b1,
        rdata:      32'h0000_0000
      };
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // dividers four to seven, each driving only its own clock
  // a ratio reaches a divider only on an apply pulse from the go sequencer,
  // so software may stage new ratios while the old ones keep running
  // divider four, clock four
  pscd_clk_div #(.RATIO_RST(pscd_pkg::SYS4_RATIO_RST), .EN_RST(pscd_pkg::DIV_EN_RST)) u_div4 (
    .i_clk     (i_clk),
    .i_rst_n   (rst_sync_q),
    .i_enable  (s_q.div_en[0]),
    .i_ratio   (s_q.div_ratio[0]),
    .i_apply   (s_q.apply[0]),
    .i_restart (s_q.restart[0]),
    .o_tick    (o_system_clock_output_tick[0]),
    .o_running (div_run[0])
  );

  // divider five, clock five
  pscd_clk_div #(.RATIO_RST(pscd_pkg::SYS5_RATIO_RST), .EN_RST(pscd_pkg::DIV_EN_RST)) u_div5 (
    .i_clk     (i_clk),
    .i_rst_n   (rst_sync_q),
    .i_enable  (s_q.div_en[1]),
    .i_ratio   (s_q.div_ratio[1]),
    .i_apply   (s_q.apply[1]),
    .i_restart (s_q.restart[1]),
    .o_tick    (o_system_clock_output_tick[1]),
    .o_running (div_run[1])
  );

  // divider six, clock six
  pscd_clk_div #(.RATIO_RST(pscd_pkg::SYS6_RATIO_RST), .EN_RST(pscd_pkg::DIV_EN_RST)) u_div6 (
    .i_clk     (i_clk),
    .i_rst_n   (rst_sync_q),
    .i_enable  (s_q.div_en[2]),
    .i_ratio   (s_q.div_ratio[2]),
    .i_apply   (s_q.apply[2]),
    .i_restart (s_q.restart[2]),
    .o_tick    (o_system_clock_output_tick[2]),
    .o_running (div_run[2])
  );

  // divider seven, clock seven
  pscd_clk_div #(.RATIO_RST(pscd_pkg::RATIO_CHANGED_SEVEN_RATIO_RST), .EN_RST(pscd_pkg::DIV_EN_RST)) u_div7 (
    .i_clk     (i_clk),
    .i_rst_n   (rst_sync_q),
    .i_enable  (s_q.div_en[3]),
    .i_ratio   (s_q.div_ratio[3]),
    .i_apply   (s_q.apply[3]),
    .i_restart (s_q.restart[3]),
    .o_tick    (o_system_clock_output_tick[3]),
    .o_running (div_run[3])
  );

  // post-divider, ratio applied directly on write
  // its running flag has no status bit here, so it is left open
  pscd_clk_div #(.RATIO_RST(pscd_pkg::POST_RATIO_RST), .EN_RST(pscd_pkg::POST_EN_RST)) u_post (
    .i_clk     (i_clk),
    .i_rst_n   (rst_sync_q),
    .i_enable  (s_q.post_en),
    .i_ratio   (s_q.post_ratio),
    .i_apply   (s_q.post_apply),
    .i_restart (1'b0),
    .o_tick    (o_post_tick),
    .o_running ()
  );

  // oscillator settling counter
  // stable is only reported, it does not hold back the bus or the dividers
  pscd_osc_settle u_settle (
    .i_clk    (i_clk),
    .i_rst_n  (rst_sync_q),
    .o_stable (osc_stable)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // registered outputs
  // every output is a flop: readdata, stall and the aux gate come from s_q
  assign o_avs_readdata    = s_q.rdata;
  assign o_avs_waitrequest = s_q.stall;
  assign o_aux_on          = s_q.aux_on;

endmodule

// ==== pscd_top_bench.sv ====
// pscd_top_bench: self-checking bench for the system_clock_output divider control block
// assumes: one 20 MHz clock; registers reached over avalon-mm with waitrequest
`timescale 1ns/1ps
module pscd_top_bench;
  logic        clk     = 1'b0;
  logic        nrst    = 1'b0;
  logic [8:0]  addr    = 9'h000;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wd      = 32'h0;
  logic [3:0]  be      = 4'hF;
  logic [2:0]  low_on  = 3'h5;
  logic [31:0] rdata;
  logic        waitreq;
  logic [3:0]  tick;
  logic        post_tick;
  logic        aux_on;
  logic [4:0]  strobes;
  int          n_errors    = 0;
  int          check_count = 0;

  assign strobes = {post_tick, tick};

  pscd_top pscd_top_inst (
    .i_clk(clk), .i_nrst(nrst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(be), .i_system_clock_output_low_on(low_on), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .o_system_clock_output_tick(tick), .o_post_tick(post_tick), .o_aux_on(aux_on)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock, verdict and helpers
  always #25 clk = ~clk;

  task automatic conclude;
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin
      n_errors++;
      conclude();
    end
  endtask

  task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // cycles between two strobes of one output
  task automatic period(input int k, input int exp);
    int n;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (strobes[k] !== 1'b1 && n < 100);
    end
    check(32'(n), 32'(exp));
    if (n >= 100) begin
      conclude();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    rd_chk(pscd_pkg::OFF_SYSCLK4_DIVIDER, 32'h00008003);
    rd_chk(pscd_pkg::OFF_SYSCLK5_DIVIDER, 32'h00008002);
    rd_chk(pscd_pkg::OFF_SYSCLK6_DIVIDER, 32'h00008000);
    rd_chk(pscd_pkg::OFF_SYSCLK7_DIVIDER, 32'h00008005);
    rd_chk(pscd_pkg::OFF_POST_DIVIDER_CONTROL, 32'h00008001);
    rd_chk(pscd_pkg::OFF_PLL_STATUS, 32'h00000004);
    rd_chk(pscd_pkg::OFF_RATIO_CHANGE_STATUS, 32'h0);
    rd_chk(pscd_pkg::OFF_AUX_CLOCK_STATUS, 32'h00000003);
    rd_chk(pscd_pkg::OFF_SYSTEM_CLOCK_OUTPUT_ON_STATUS, 32'h0000007D);
    rd_chk(pscd_pkg::OFF_ALIGNMENT_MASK, 32'h0);
    rd_chk(pscd_pkg::OFF_AUX_CLOCK_ENABLE, 32'h00000003);
    rd_chk(pscd_pkg::OFF_COMMAND_REGISTER, 32'h0);
  endtask

  task automatic t_periods;
    period(0, 4);
    period(1, 3);
    period(2, 1);
    period(3, 6);
    period(4, 2);
  endtask

  // pending ratio reaches clock four only through go alignment
  task automatic t_go;
    logic [31:0] q;
    int n;
    wr_reg(pscd_pkg::OFF_SYSCLK4_DIVIDER, 32'h00008006);
    rd_chk(pscd_pkg::OFF_RATIO_CHANGE_STATUS, 32'h00000008);
    period(0, 4);
    wr_reg(pscd_pkg::OFF_ALIGNMENT_MASK, 32'h00000008);
    rd_chk(pscd_pkg::OFF_ALIGNMENT_MASK, 32'h00000008);
    wr_reg(pscd_pkg::OFF_COMMAND_REGISTER, 32'h0);
    rd_chk(pscd_pkg::OFF_PLL_STATUS, 32'h00000004);
    wr_reg(pscd_pkg::OFF_COMMAND_REGISTER, 32'h00000001);
    rd_chk(pscd_pkg::OFF_PLL_STATUS, 32'h00000005);
    rd_chk(pscd_pkg::OFF_COMMAND_REGISTER, 32'h00000001);
    n = 0;
    do begin
      bus(1'b0, pscd_pkg::OFF_PLL_STATUS, 32'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 10);
    check(q, 32'h00000004);
    if (q[0] !== 1'b0) begin
      conclude();
    end
    rd_chk(pscd_pkg::OFF_RATIO_CHANGE_STATUS, 32'h0);
    period(0, 7);
  endtask

  // disabling divider five stops only clock five
  task automatic t_enable;
    int n;
    be <= 4'h2;  // enable lane only, the staged ratio must not move
    wr_reg(pscd_pkg::OFF_SYSCLK5_DIVIDER, 32'h00000002);
    be <= 4'hF;
    n = 0;
    repeat (12) begin
      @(posedge clk);
      n += int'(tick[1] !== 1'b0);
    end
    check(32'(n), 32'h0);
    low_on <= 3'h1;
    rd_chk(pscd_pkg::OFF_SYSTEM_CLOCK_OUTPUT_ON_STATUS, 32'h00000069);
    rd_chk(pscd_pkg::OFF_RATIO_CHANGE_STATUS, 32'h0);
    period(3, 6);
    wr_reg(pscd_pkg::OFF_SYSCLK5_DIVIDER, 32'h00008002);
    period(1, 3);
    rd_chk(pscd_pkg::OFF_RATIO_CHANGE_STATUS, 32'h00000010);
  endtask

  task automatic t_aux;
    wr_reg(pscd_pkg::OFF_AUX_CLOCK_ENABLE, 32'h00000002);
    repeat (2) @(posedge clk);
    check({31'h0, aux_on}, 32'h0);
    rd_chk(pscd_pkg::OFF_AUX_CLOCK_STATUS, 32'h00000002);
    wr_reg(pscd_pkg::OFF_AUX_CLOCK_ENABLE, 32'h00000003);
    rd_chk(pscd_pkg::OFF_AUX_CLOCK_STATUS, 32'h00000003);
  endtask

  // unmapped read and a write to a read-only register
  task automatic t_refuse;
    rd_chk(9'h000, 32'h0);
    wr_reg(pscd_pkg::OFF_PLL_STATUS, 32'hFFFFFFFF);
    rd_chk(pscd_pkg::OFF_PLL_STATUS, 32'h00000004);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (20) @(posedge clk);
    t_reset();
    t_periods();
    t_go();
    t_enable();
    t_aux();
    t_refuse();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule
